// ### logic/sdcc_defines.vh
// constants for the sigma-delta conversion control block
`ifndef SDCC_DEFINES_VH
`define SDCC_DEFINES_VH

// timing
`define SDCC_CLK_HZ      100000000
`define SDCC_MCLK_HZ     2000000
`define SDCC_MCLK_DIV    (`SDCC_CLK_HZ / `SDCC_MCLK_HZ)
`define SDCC_MOD_DIV     512
`define SDCC_SAMP_DIV    256
`define SDCC_NOTCH_HZ    60
`define SDCC_NOTCH_RST   (`SDCC_MCLK_HZ / `SDCC_MOD_DIV / `SDCC_NOTCH_HZ)
`define SDCC_CODE_MIN    12'h013
`define SDCC_CODE_MAX    12'h7D0
`define SDCC_SETTLE_OUT  2'h3
`define SDCC_GAIN_MAXSH  3'h3

// register byte offsets
`define SDCC_ADR_CTRL    8'h00
`define SDCC_ADR_STAT    8'h04
`define SDCC_ADR_DATA    8'h08
`define SDCC_ADR_OFFS    8'h0C
`define SDCC_ADR_GAIN    8'h10

// control register fields
`define SDCC_CODE_LSB    0
`define SDCC_GSEL_LSB    12
`define SDCC_CH_LSB      16
`define SDCC_MODE_LSB    18

// calibration modes
`define SDCC_MODE_NORM   3'h0
`define SDCC_MODE_SELF   3'h1
`define SDCC_MODE_SZERO  3'h2
`define SDCC_MODE_SFULL  3'h3
`define SDCC_MODE_BACK   3'h4

// coefficient reset values, gain is unsigned Q2.22
`define SDCC_OFFS_RST    24'h000000
`define SDCC_GAIN_RST    24'h400000
`define SDCC_GAIN_FRAC   22
`define SDCC_GAIN_NUM    48'h200000000000

// analogue path select codes
`define SDCC_CAL_EXT     2'h0
`define SDCC_CAL_ZERO    2'h1
`define SDCC_CAL_FULL    2'h2

`endif

// ### logic/sdcc_cic3.v
// third-order comb-integrator decimator for the modulator bit stream
`default_nettype none

module sdcc_cic3 #(
  parameter CW = 12,                    // width of decimation ratio
  parameter AW = 36                     // accumulator width
) (
  input  wire                 clk_i,     // system clock
  input  wire                 rst_i,     // synchronous reset
  input  wire                 clr_i,     // filter restart
  input  wire                 in_vld_i,  // one modulator sample
  input  wire                 in_bit_i,  // modulator bit
  input  wire [CW-1:0]        ratio_i,   // samples per output
  output reg                  out_vld_o, // result pulse
  output reg  signed [AW-1:0] out_dat_o  // filtered result
);

  reg signed [AW-1:0] int1;             // first integrator
  reg signed [AW-1:0] int2;             // second integrator
  reg signed [AW-1:0] int3;             // third integrator
  reg signed [AW-1:0] dly1;             // comb delays
  reg signed [AW-1:0] dly2;
  reg signed [AW-1:0] dly3;
  reg        [CW-1:0] dec_cnt;          // decimation phase
  wire signed [AW-1:0] step;            // +1 or -1 per bit
  wire signed [AW-1:0] comb1;
  wire signed [AW-1:0] comb2;
  wire       [CW-1:0] last;             // final phase of a period

  assign step  = {{(AW-1){~in_bit_i}}, 1'b1};
  assign comb1 = int3 - dly1;
  assign comb2 = comb1 - dly2;
  assign last  = ratio_i - {{(CW-1){1'b0}}, 1'b1};

  // integrators at input rate, combs at output rate
  always @(posedge clk_i) begin
    out_vld_o <= 1'b0;
    if (rst_i || clr_i) begin
      int1      <= {AW{1'b0}};
      int2      <= {AW{1'b0}};
      int3      <= {AW{1'b0}};
      dly1      <= {AW{1'b0}};
      dly2      <= {AW{1'b0}};
      dly3      <= {AW{1'b0}};
      dec_cnt   <= {CW{1'b0}};
      out_dat_o <= {AW{1'b0}};
    end else if (in_vld_i) begin
      int1 <= int1 + step;
      int2 <= int2 + int1;
      int3 <= int3 + int2;
      if (dec_cnt >= last) begin       // period complete
        dec_cnt   <= {CW{1'b0}};
        dly1      <= int3;
        dly2      <= comb1;
        dly3      <= comb2;
        out_dat_o <= comb2 - dly3;
        out_vld_o <= 1'b1;
      end else begin
        dec_cnt <= dec_cnt + {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule

`default_nettype wire

// ### logic/sdcc_ctrl.v
// sigma-delta conversion control with wishbone register slave
//
// Added by the designer: the Wishbone interface to the registers and the register addresses.
`default_nettype none
`include "sdcc_defines.vh"

module sdcc_ctrl #(
  parameter AW = 36                     // filter accumulator width
) (
  input  wire        clk_i,             // system clock, 100 MHz
  input  wire        rst_i,             // synchronous reset, high
  input  wire        wb_cyc_i,          // wishbone cycle
  input  wire        wb_stb_i,          // wishbone strobe
  input  wire        wb_we_i,           // wishbone write
  input  wire [7:0]  wb_adr_i,          // byte address
  input  wire [3:0]  wb_sel_i,          // byte enables
  input  wire [31:0] wb_dat_i,          // write data
  output reg  [31:0] wb_dat_o,          // read data
  output reg         wb_ack_o,          // acknowledge
  input  wire        mod_bit_i,         // modulator bit stream pin
  input  wire        sync_n_i,          // filter sync pin, low holds
  input  wire        stby_n_i,          // standby pin, low idles
  output reg         rdy_n_o,           // low while unread data
  output reg         samp_o,            // input sampling strobe
  output reg  [1:0]  ch_sel_o,          // selected input channel
  output reg  [2:0]  gain_o,            // gain as power of two
  output reg  [1:0]  cal_sel_o,         // analogue path select
  output reg         pwr_dn_o           // analogue power down
);

  // states of the calibration sequencer
  localparam ST_RUN  = 2'h0;            // normal conversion
  localparam ST_ZERO = 2'h1;            // zero-scale measure
  localparam ST_FULL = 2'h2;            // full-scale measure
  localparam ST_DIV  = 2'h3;            // gain coefficient search
  localparam [31:0] NOTCH_RST = `SDCC_NOTCH_RST; // 60 Hz reset code

  // control fields and coefficients
  reg [11:0] notch_code_field;          // decimation code
  reg [2:0]  mode;                      // calibration mode
  reg [23:0] offs_coef;                 // offset coefficient
  reg [23:0] gain_coef;                 // gain coefficient
  reg [23:0] data_reg;                  // output register
  reg        rdy;                       // unread result present
  reg [1:0]  state;                     // sequencer state
  reg [23:0] span;                      // measured full-scale span
  reg [23:0] quo;                       // gain search value
  reg [4:0]  bit_idx;                   // gain search bit

  // pin synchronisers: mod bit, sync, standby
  reg [2:0]  pin_s1;
  reg [2:0]  pin_s2;
  reg [2:0]  pin_s3;
  reg [2:0]  pin_f;                     // agreed pin levels

  // timing chains
  reg [5:0]  mck_cnt;                   // master clock divider
  reg        mck_tick;                  // master clock enable pulse
  reg [8:0]  mod_cnt;                   // modulator cycle count
  reg [7:0]  smp_cnt;                   // sampling period count

  // filter interface
  reg                 flt_clr;          // filter restart
  reg                 mod_vld;          // modulator sample strobe
  wire                flt_vld;
  wire signed [AW-1:0] flt_dat;
  reg [1:0]           settle_cnt;       // results since restart
  reg                 take;             // settled result ready
  reg [23:0]          raw_q;            // saturated filter result

  // combinational helpers
  reg  [31:0] wmask;                    // byte-enable mask
  reg  [31:0] ctrl_word;                // control read value
  reg  [31:0] next_ctrl;                // control after write
  reg  [7:0]  smp_period;               // ticks per input sample
  wire signed [24:0] diff;              // raw minus offset
  wire signed [49:0] prod;              // offset-corrected times gain
  wire [23:0] corr;                     // corrected result
  wire signed [24:0] span_d;            // full minus zero
  wire [23:0] trial;                    // search candidate
  wire [47:0] trial_p;                  // candidate times span
  wire        wb_req;                   // new bus request
  wire        ctrl_wr;                  // control register write
  wire        stby;                     // standby active
  wire [2:0]  nmode;                    // mode in new control word
  wire [1:0]  nch;                      // channel in new word
  wire [11:0] ncode;                    // code in new word

  // clamp to signed 24-bit range
  function [23:0] sat24;
    input signed [49:0] v;
    begin
      if (v > 50'sh00000007FFFFF)
        sat24 = 24'h7FFFFF;
      else if (v < -50'sh00000000800000)
        sat24 = 24'h800000;
      else
        sat24 = v[23:0];
    end
  endfunction

  // keep code within the legal decimation range
  function [11:0] clamp_code;
    input [11:0] c;
    begin
      if (c < `SDCC_CODE_MIN)
        clamp_code = `SDCC_CODE_MIN;
      else if (c > `SDCC_CODE_MAX)
        clamp_code = `SDCC_CODE_MAX;
      else
        clamp_code = c;
    end
  endfunction

  sdcc_cic3 #(
    .CW (12),
    .AW (AW)
  ) u_cic3 (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .clr_i     (flt_clr),
    .in_vld_i  (mod_vld),
    .in_bit_i  (pin_f[0]),
    .ratio_i   (notch_code_field),
    .out_vld_o (flt_vld),
    .out_dat_o (flt_dat)
  );

  assign stby    = ~pin_f[2];
  assign wb_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign ctrl_wr = wb_req & wb_we_i & (wb_adr_i == `SDCC_ADR_CTRL);
  assign nmode   = next_ctrl[`SDCC_MODE_LSB +: 3];
  assign nch     = next_ctrl[`SDCC_CH_LSB +: 2];
  assign ncode   = clamp_code(next_ctrl[`SDCC_CODE_LSB +: 12]);

  // correction: (raw - offset) * gain, gain unity at 2^22
  assign diff    = $signed({raw_q[23], raw_q}) -
                   $signed({offs_coef[23], offs_coef});
  assign prod    = diff * $signed({1'b0, gain_coef});
  assign corr    = sat24(prod >>> `SDCC_GAIN_FRAC);
  assign span_d  = diff;
  assign trial   = quo | (24'h000001 << bit_idx);
  assign trial_p = trial * span;

  // bus helpers and control word image
  always @* begin
    wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
             {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    ctrl_word = {11'h000, mode, ch_sel_o, 1'b0, gain_o,
                 notch_code_field};
    next_ctrl = (ctrl_word & ~wmask) | (wb_dat_i & wmask);
    // input sampling faster with gain, capped at eight times
    if (gain_o > `SDCC_GAIN_MAXSH)
      smp_period = 8'hFF >> `SDCC_GAIN_MAXSH;
    else
      smp_period = 8'hFF >> gain_o;
  end

  // pin synchronisers: a change counts once stages 2 and 3 agree
  always @(posedge clk_i) begin
    if (rst_i) begin
      pin_s1 <= 3'h7;
      pin_s2 <= 3'h7;
      pin_s3 <= 3'h7;
      pin_f  <= 3'h7;
    end else begin
      pin_s1 <= {stby_n_i, sync_n_i, mod_bit_i};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_f  <= (~(pin_s2 ^ pin_s3) & pin_s3) |
                ((pin_s2 ^ pin_s3) & pin_f);
    end
  end

  // master clock, modulator and sampling timebase
  always @(posedge clk_i) begin
    mck_tick <= 1'b0;
    mod_vld  <= 1'b0;
    samp_o   <= 1'b0;
    if (rst_i || stby) begin           // timebase cleared and held at zero in standby
      mck_cnt <= 6'h00;
      mod_cnt <= 9'h000;
      smp_cnt <= 8'h00;
    end else begin
      if (mck_cnt == `SDCC_MCLK_DIV - 1) begin
        mck_cnt  <= 6'h00;
        mck_tick <= 1'b1;
      end else begin
        mck_cnt <= mck_cnt + 6'h01;
      end
      if (mck_tick) begin
        // one modulator sample per 512 master clocks
        if (mod_cnt == `SDCC_MOD_DIV - 1) begin
          mod_cnt <= 9'h000;
          mod_vld <= 1'b1;
        end else begin
          mod_cnt <= mod_cnt + 9'h001;
        end
        if (smp_cnt >= smp_period) begin
          smp_cnt <= 8'h00;
          samp_o  <= 1'b1;
        end else begin
          smp_cnt <= smp_cnt + 8'h01;
        end
      end
    end
  end

  // settle tracking: drop results until the third after restart
  always @(posedge clk_i) begin
    take <= 1'b0;
    if (rst_i || flt_clr) begin
      settle_cnt <= 2'h0;
    end else if (flt_vld) begin
      if (settle_cnt == `SDCC_SETTLE_OUT - 2'h1) begin
        take  <= 1'b1;
        raw_q <= sat24({{(50-AW){flt_dat[AW-1]}}, flt_dat});
      end else begin
        settle_cnt <= settle_cnt + 2'h1;
      end
    end
  end

  // registers, bus slave and calibration sequencer
  always @(posedge clk_i) begin
    wb_ack_o <= wb_req;                 // answer one cycle after request
    flt_clr  <= stby | ~pin_f[1];
    pwr_dn_o <= stby;
    rdy_n_o  <= ~rdy;
    if (rst_i) begin
      notch_code_field <= NOTCH_RST[11:0];
      gain_o    <= 3'h0;
      ch_sel_o  <= 2'h0;
      mode      <= `SDCC_MODE_NORM;
      offs_coef <= `SDCC_OFFS_RST;
      gain_coef <= `SDCC_GAIN_RST;
      data_reg  <= 24'h000000;
      rdy       <= 1'b0;
      state     <= ST_RUN;
      cal_sel_o <= `SDCC_CAL_EXT;
      span      <= 24'h000000;
      quo       <= 24'h000000;
      bit_idx   <= 5'h00;
      wb_dat_o  <= 32'h00000000;
      wb_ack_o  <= 1'b0;
      flt_clr   <= 1'b1;
      pwr_dn_o  <= 1'b0;
      rdy_n_o   <= 1'b1;
    end else begin
      // sequencer
      case (state)
        ST_RUN: begin
          cal_sel_o <= `SDCC_CAL_EXT;
          if (take) begin
            data_reg <= corr;
            rdy      <= 1'b1;
            if (mode == `SDCC_MODE_BACK) begin
              state     <= ST_ZERO;
              cal_sel_o <= `SDCC_CAL_ZERO;
              flt_clr   <= 1'b1;
            end
          end
        end
        ST_ZERO: begin
          if (take) begin
            offs_coef <= raw_q;
            flt_clr   <= 1'b1;
            if (mode == `SDCC_MODE_SZERO) begin
              state <= ST_RUN;
              mode  <= `SDCC_MODE_NORM;
            end else begin
              state     <= ST_FULL;
              cal_sel_o <= `SDCC_CAL_FULL;
            end
          end
        end
        ST_FULL: begin
          if (take) begin
            // non-positive span keeps the old gain
            if (span_d > 25'sh0000000) begin
              span    <= span_d[23:0];
              quo     <= 24'h000000;
              bit_idx <= 5'h17;
              state   <= ST_DIV;
            end else begin
              state   <= ST_RUN;
              flt_clr <= 1'b1;
              if (mode != `SDCC_MODE_BACK)
                mode <= `SDCC_MODE_NORM;
            end
          end
        end
        ST_DIV: begin
          // successive approximation of 2^45 / span
          if (trial_p <= `SDCC_GAIN_NUM)
            quo <= trial;
          if (bit_idx == 5'h00) begin
            gain_coef <= (trial_p <= `SDCC_GAIN_NUM) ? trial : quo;
            state     <= ST_RUN;
            cal_sel_o <= `SDCC_CAL_EXT;
            flt_clr   <= 1'b1;
            if (mode != `SDCC_MODE_BACK)
              mode <= `SDCC_MODE_NORM;
          end else begin
            bit_idx <= bit_idx - 5'h01;
          end
        end
        default: begin
          state <= ST_RUN;
        end
      endcase

      // bus access, later writes win over the sequencer
      if (wb_req) begin
        wb_dat_o <= 32'h00000000;       // unmapped reads as zero
        case (wb_adr_i)
          `SDCC_ADR_CTRL: begin
            wb_dat_o <= ctrl_word;
            if (wb_we_i) begin
              notch_code_field <= ncode;
              gain_o   <= next_ctrl[`SDCC_GSEL_LSB +: 3];
              ch_sel_o <= (nch == 2'h3) ? 2'h2 : nch;
              mode     <= nmode;
              flt_clr  <= 1'b1;
              // a calibration mode starts its sequence at once
              case (nmode)
                `SDCC_MODE_SELF, `SDCC_MODE_BACK: begin
                  state     <= ST_ZERO;
                  cal_sel_o <= `SDCC_CAL_ZERO;
                end
                `SDCC_MODE_SZERO: begin
                  state     <= ST_ZERO;
                  cal_sel_o <= `SDCC_CAL_EXT;
                end
                `SDCC_MODE_SFULL: begin
                  state     <= ST_FULL;
                  cal_sel_o <= `SDCC_CAL_EXT;
                end
                default: begin
                  state     <= ST_RUN;
                  cal_sel_o <= `SDCC_CAL_EXT;
                  mode      <= `SDCC_MODE_NORM;
                end
              endcase
            end
          end
          `SDCC_ADR_STAT: begin
            wb_dat_o <= {28'h0000000, ~pin_f[1], stby,
                         (state != ST_RUN), rdy};
          end
          `SDCC_ADR_DATA: begin
            wb_dat_o <= {8'h00, data_reg};
            // a new result in the same cycle keeps the flag set
            if (!wb_we_i && !(state == ST_RUN && take))
              rdy <= 1'b0;
          end
          `SDCC_ADR_OFFS: begin
            wb_dat_o <= {8'h00, offs_coef};
            if (wb_we_i)
              offs_coef <= (offs_coef & ~wmask[23:0]) |
                           (wb_dat_i[23:0] & wmask[23:0]);
          end
          `SDCC_ADR_GAIN: begin
            wb_dat_o <= {8'h00, gain_coef};
            if (wb_we_i)
              gain_coef <= (gain_coef & ~wmask[23:0]) |
                           (wb_dat_i[23:0] & wmask[23:0]);
          end
          default: begin
            wb_dat_o <= 32'h00000000;
          end
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// ### logic/sdcc_placeholder_unused.v
// intentionally empty design unit kept out of the build
`default_nettype none
`default_nettype wire

// ### verif/sdcc_mod_model.sv
// behavioural modulator front end feeding the bit stream pin
`default_nettype none
`include "sdcc_defines.vh"

module sdcc_mod_model (
  input  wire logic       clk_i,     // system clock
  input  wire logic       rst_i,     // synchronous reset
  input  wire logic [1:0] cal_sel_i, // analogue path select
  input  wire logic       pwr_dn_i,  // front end powered down
  output logic            mod_bit_o  // modulator bit stream
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] acc;                   // first-order loop state
  logic [7:0] lvl;                   // ones density of the path

  // density per path: zero is mid scale, full is high
  always_comb begin
    if (cal_sel_i == `SDCC_CAL_ZERO) begin
      lvl = 8'h80;
    end else if (cal_sel_i == `SDCC_CAL_FULL) begin
      lvl = 8'hE0;
    end else begin
      lvl = 8'hA0;
    end
  end

  // released line toggles so a stale level cannot pass
  always @(posedge clk_i) begin
    if (rst_i) begin
      acc <= 8'h00;
      mod_bit_o <= 1'b0;
    end else if (pwr_dn_i) begin
      mod_bit_o <= ~mod_bit_o;
    end else begin
      {mod_bit_o, acc} <= {1'b0, acc} + {1'b0, lvl};
    end
  end
endmodule

`default_nettype wire

// ### verif/sdcc_ctrl_checker.sv
// concurrent checks on the conversion control ports
`default_nettype none
`include "sdcc_defines.vh"

module sdcc_ctrl_checker (
  input wire logic        clk_i,    // system clock
  input wire logic        rst_i,    // synchronous reset
  input wire logic        wb_cyc_i, // bus cycle
  input wire logic        wb_stb_i, // bus strobe
  input wire logic        wb_we_i,  // bus write
  input wire logic [7:0]  wb_adr_i, // byte address
  input wire logic [31:0] wb_dat_o, // read data
  input wire logic        wb_ack_o, // acknowledge
  input wire logic        stby_n_i, // standby pin
  input wire logic        rdy_n_o,  // data ready, low
  input wire logic        samp_o,   // sampling strobe
  input wire logic [1:0]  ch_sel_o, // channel select
  input wire logic        pwr_dn_o  // power down
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // a request the slave takes at this edge
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // a read request of one offset
  sequence s_rd(a);
    s_take ##0 (!wb_we_i && wb_adr_i == a);
  endsequence
  sequence s_unmapped;
    s_take ##0 (!wb_we_i && wb_adr_i != `SDCC_ADR_CTRL &&
      wb_adr_i != `SDCC_ADR_STAT && wb_adr_i != `SDCC_ADR_DATA &&
      wb_adr_i != `SDCC_ADR_OFFS && wb_adr_i != `SDCC_ADR_GAIN);
  endsequence

  a_ack_next: assert property (s_take |=> wb_ack_o)
    else $error("request not acknowledged next cycle");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  a_code_range: assert property (s_rd(`SDCC_ADR_CTRL) |=>
    (wb_dat_o[11:0] >= 12'h013 && wb_dat_o[11:0] <= 12'h7D0))
    else $error("notch code out of range");
  a_unmapped_zero: assert property (s_unmapped |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_read_clears: assert property (s_rd(`SDCC_ADR_DATA) |=> ##1 rdy_n_o)
    else $error("ready not cleared by data read");
  a_stby_idle: assert property (!stby_n_i [*6] |-> pwr_dn_o)
    else $error("standby not entered");
  a_stby_wake: assert property (stby_n_i [*6] |-> !pwr_dn_o)
    else $error("standby not left");
  a_idle_no_samp: assert property (pwr_dn_o [*2] |-> !samp_o)
    else $error("sampling while in standby");
  a_samp_pulse: assert property (samp_o |=> !samp_o)
    else $error("sampling strobe too long");
  a_chan_legal: assert property (ch_sel_o != 2'h3)
    else $error("illegal channel selected");
endmodule

bind sdcc_ctrl sdcc_ctrl_checker u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .stby_n_i(stby_n_i), .rdy_n_o(rdy_n_o), .samp_o(samp_o),
  .ch_sel_o(ch_sel_o), .pwr_dn_o(pwr_dn_o));

`default_nettype wire

// ### verif/tb_top.sv
// self-checking bench for the conversion control block
`default_nettype none
`include "sdcc_defines.vh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0;   // system clock
  logic        rst_i = 1'b1;   // synchronous reset
  logic        cyc   = 1'b0;   // bus cycle
  logic        stb   = 1'b0;   // bus strobe
  logic        we    = 1'b0;   // bus write
  logic [7:0]  adr   = 8'h00;  // bus address
  logic [3:0]  sel   = 4'h0;   // byte enables
  logic [31:0] wdat  = 32'h0;  // write data
  logic        stby_n = 1'b1;  // standby pin
  logic        sync_n = 1'b1;  // filter sync pin
  wire  [31:0] rdat;           // read data
  wire         ack;            // acknowledge
  wire         mbit;           // modulator bits
  wire         rdy_n;          // data ready, low
  wire         samp;           // sampling strobe
  wire  [1:0]  ch_sel;         // channel select
  wire  [2:0]  gain;           // gain exponent
  wire  [1:0]  cal_sel;        // path select
  wire         pwr_dn;         // power down
  int          n_fail = 0;     // mismatches
  int          total_checks = 0; // comparisons
  int          cycles = 0;     // timeout counter
  logic [31:0] q;              // last read word

  sdcc_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .mod_bit_i(mbit),
    .sync_n_i(sync_n), .stby_n_i(stby_n), .rdy_n_o(rdy_n), .samp_o(samp),
    .ch_sel_o(ch_sel), .gain_o(gain), .cal_sel_o(cal_sel),
    .pwr_dn_o(pwr_dn));
  sdcc_mod_model u_mod (.clk_i(clk_i), .rst_i(rst_i), .cal_sel_i(cal_sel),
    .pwr_dn_i(pwr_dn), .mod_bit_o(mbit));

  always #5 clk_i = ~clk_i;

  // whole run needs about 65k cycles; a hang is cut here
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 90000) begin
      n_fail++;
      $display("BAD %0t run timed out", $time);
      report_and_stop();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp, input string s);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask

  // classic single cycle, held until ack is sampled
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp, input string s);
    wb(1'b0, a, 32'h0);
    chk(q, exp, s);
  endtask

  // control word from its fields
  function automatic logic [31:0] cw(int m, int c, int g, int code);
    return (m << 18) | (c << 16) | (g << 12) | code;
  endfunction

  task t_reset;
    rd(`SDCC_ADR_CTRL, 32'(`SDCC_NOTCH_RST), "reset ctrl");
    rd(`SDCC_ADR_OFFS, 32'(`SDCC_OFFS_RST), "reset offs");
    rd(`SDCC_ADR_GAIN, 32'(`SDCC_GAIN_RST), "reset gain");
    rd(`SDCC_ADR_STAT, 32'h0, "reset stat");
    rd(8'h14, 32'h0, "unmapped");
    rd(`SDCC_ADR_DATA, 32'h0, "reset data");
    chk(32'(rdy_n), 32'h1, "reset ready");
    $display("test reset done");
  endtask

  // out of range codes clamp; channel 3 folds to 2
  task t_ctrl;
    int code[4] = '{5, 4095, 19, 2000};
    int expc[4] = '{19, 2000, 19, 2000};
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, `SDCC_ADR_CTRL, cw(0, i, i, code[i]));
      rd(`SDCC_ADR_CTRL, cw(0, i > 2 ? 2 : i, i, expc[i]), "code");
      chk(32'(ch_sel), 32'(i > 2 ? 2 : i), "channel");
    end
    $display("test ctrl done");
  endtask

  task t_coef;
    wb(1'b1, `SDCC_ADR_OFFS, 32'h00123456);
    wb(1'b1, `SDCC_ADR_GAIN, 32'hFF3FFFFF);
    wb(1'b1, `SDCC_ADR_STAT, 32'hFFFFFFFF);
    rd(`SDCC_ADR_OFFS, 32'h00123456, "offs rw");
    rd(`SDCC_ADR_GAIN, 32'h003FFFFF, "gain rw");
    rd(`SDCC_ADR_STAT, 32'h0, "stat ro");
    $display("test coef done");
  endtask

  // strobe spacing shrinks with gain up to eight
  task t_samp;
    int n;
    for (int g = 0; g < 8; g++) begin
      wb(1'b1, `SDCC_ADR_CTRL, cw(0, 0, g, 19));
      chk(32'(gain), 32'(g), "gain out");
      do @(posedge clk_i); while (samp !== 1'b1);
      n = 0;
      do begin
        @(posedge clk_i);
        n++;
      end while (samp !== 1'b1);
      chk(n, ((255 >> (g > 3 ? 3 : g)) + 1) * `SDCC_MCLK_DIV, "period");
    end
    $display("test samp done");
  endtask

  task t_stby;
    int n;
    stby_n <= 1'b0;
    sync_n <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk(32'(pwr_dn), 32'h1, "pwr down");
    wb(1'b0, `SDCC_ADR_STAT, 32'h0);
    chk(q & 32'hC, 32'hC, "stat idle");
    n = 0;
    repeat (2000) @(posedge clk_i) n += samp;
    chk(n, 0, "idle strobes");
    stby_n <= 1'b1;
    sync_n <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk(32'(pwr_dn), 32'h0, "pwr up");
    n = 0;
    repeat (2000) @(posedge clk_i) n += samp;
    chk(32'(n > 0), 32'h1, "strobes back");
    $display("test stby done");
  endtask

  // each calibration mode write starts a new calibration at once
  task t_cal;
    int m[4] = '{1, 2, 3, 4};
    int p[4] = '{1, 0, 0, 1};
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, `SDCC_ADR_CTRL, cw(m[i], 0, 0, 19));
      repeat (8) @(posedge clk_i);
      chk(32'(cal_sel), 32'(p[i]), "cal path");
      wb(1'b0, `SDCC_ADR_STAT, 32'h0);
      chk(q & 32'h2, 32'h2, "calibrating");
    end
    $display("test cal done");
  endtask

  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_ctrl();
    t_coef();
    t_samp();
    t_stby();
    t_cal();
    report_and_stop();
  end
endmodule

`default_nettype wire
